// [crg_defs.vh]
// Constants for the comparator and reference generator control block.
// Assumes inclusion by crg_top.v and by the bench; holds definitions only.
`ifndef CRG_DEFS_VH
`define CRG_DEFS_VH

// =====================================================================
// Register map (printed offsets are not word multiples: index * 4)
`define CRG_IDX_CMP_CTRL 8'h19
`define CRG_IDX_REF_CTRL 8'h99
`define CRG_IDX_STATUS 8'h20
`define CRG_IDX_PINS 8'h21
`define CRG_ADDR_W 10

// =====================================================================
// Comparator control fields
`define CRG_CMP_MODE_LSB 0
`define CRG_CMP_MODE_MSB 2
`define CRG_CMP_SWITCH_BIT 3
`define CRG_CMP_INVERT_BIT 4
`define CRG_CMP_RESULT_BIT 6
`define CRG_CMP_WR_MASK 5'h1F
`define CRG_CMP_RESET 5'h00

// =====================================================================
// Reference control fields
`define CRG_REF_ENABLE_BIT 7
`define CRG_REF_RANGE_BIT 5
`define CRG_REF_TAP_MSB 3
`define CRG_REF_WR_MASK 8'hAF
`define CRG_REF_RESET 8'h00

// =====================================================================
// Status register fields
`define CRG_STAT_FLAG_BIT 0
`define CRG_STAT_MISMATCH_BIT 1
`define CRG_STAT_SLEEP_BIT 2

// =====================================================================
// Comparator modes
`define CRG_MODE_RESET 3'h0
`define CRG_MODE_OUT_A 3'h1
`define CRG_MODE_REF_A 3'h2
`define CRG_MODE_OUT_B 3'h3
`define CRG_MODE_REF_B 3'h4
`define CRG_MODE_SW_REF 3'h5
`define CRG_MODE_SW_REF_OUT 3'h6
`define CRG_MODE_OFF 3'h7

// =====================================================================
// Bus responses
`define CRG_RESP_OKAY 2'h0
`define CRG_RESP_SLVERR 2'h2

`endif

// [crg_top.v]
// Control and status logic for one analog comparator and its 32-level
// reference ladder, reached over AXI4-Lite. The analog parts sit outside
// and are steered by the level outputs below.
//
// Behaviour
// - Uninverted result: one when positive above negative
// - Invert bit flips result polarity
// - Modes 110/101: switch bit picks negative input
// - Three-bit mode field selects eight modes
// - Result bit read-only; unused bits read zero
// - Three modes drive raw result onto pin
// - Direction bit enables pin driver in output modes
// - Analog-configured pins read zero from port
// - Reference feeds comparator in four modes
// - Ladder offers 32 levels, two ranges
// - Low range level is tap over 24
// - High range level is quarter plus tap/32
// - Range bit one selects low range
// - Enable bit powers ladder, clear powers down
// - Enabled comparator and ladder stay active asleep
// - Comparator event wakes device; registers kept
// - Mode 111 and cleared enable switch off
// - Reset restores both registers, mode 000
// - Result change sets event flag
// - Comparator register access ends mismatch; mismatch re-sets flag
// - Writing one sets flag, simulated event
`include "crg_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module crg_top #(
  parameter TAP_W = 4
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // AXI4-Lite write address and data
  input wire [`CRG_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [`CRG_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Analog comparator interface
  input wire comparator_raw,
  output wire [2:0] comparator_mode_sel,
  output wire input_switch,
  output wire neg_to_noninv_pin,
  output wire ref_to_comparator,
  output wire comparator_power,
  // Reference ladder
  output wire refgen_enable,
  output wire ref_range_sel,
  output wire [TAP_W-1:0] ref_tap_sel,
  output wire [TAP_W:0] ref_level_code,
  // Output pin and shared pins
  input wire pin_direction_out_n,
  output wire comparator_output_pin_o,
  output wire comparator_output_pin_oe,
  input wire [2:0] port_pins_in,
  output wire [2:0] port_read,
  // Core side
  input wire sleep_active,
  output wire wake_request,
  output wire cmp_event_flag
);

  // ===================================================================
  // Registers
  reg [4:0] comparator_ctrl;
  reg [7:0] refgen_ctrl;
  reg flag;
  reg mismatch;
  reg sync_a;
  reg sync_b;
  reg result_q;
  reg aw_held;
  reg w_held;
  reg [`CRG_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire output_invert = comparator_ctrl[`CRG_CMP_INVERT_BIT];
  wire [2:0] mode = comparator_ctrl[`CRG_CMP_MODE_MSB:`CRG_CMP_MODE_LSB];

  // ===================================================================
  // Comparator result
  // Raw analog decision is asynchronous; only the pin path sees it raw.
  wire raw_polar = comparator_raw ^ output_invert;
  always @(posedge clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      result_q <= 1'b0;
    end else begin
      sync_a <= raw_polar;
      sync_b <= sync_a;
      result_q <= sync_b;
    end
  end
  wire comparator_result = sync_b;
  wire result_changed = sync_b ^ result_q;

  // ===================================================================
  // Mode decode
  // One table for all eight codes, so a new mapping is a local change
  reg dec_on;
  reg dec_output;
  reg dec_ref;
  reg dec_switch;
  always @* begin
    dec_on = 1'b1;
    dec_output = 1'b0;
    dec_ref = 1'b0;
    dec_switch = 1'b0;
    case (mode)
      `CRG_MODE_RESET: begin
        dec_on = 1'b0;
      end
      `CRG_MODE_OUT_A: begin
        dec_output = 1'b1;
      end
      `CRG_MODE_REF_A: begin
        dec_ref = 1'b1;
      end
      `CRG_MODE_OUT_B: begin
        dec_output = 1'b1;
      end
      `CRG_MODE_REF_B: begin
        dec_ref = 1'b1;
      end
      `CRG_MODE_SW_REF: begin
        dec_ref = 1'b1;
        dec_switch = 1'b1;
      end
      `CRG_MODE_SW_REF_OUT: begin
        dec_output = 1'b1;
        dec_ref = 1'b1;
        dec_switch = 1'b1;
      end
      `CRG_MODE_OFF: begin
        dec_on = 1'b0;
      end
      default: begin
        dec_on = 1'b0;
      end
    endcase
  end
  wire mode_on = dec_on;
  wire mode_output = dec_output;
  wire mode_ref = dec_ref;
  wire mode_switch = dec_switch;

  assign comparator_mode_sel = mode;
  assign input_switch = comparator_ctrl[`CRG_CMP_SWITCH_BIT];
  assign neg_to_noninv_pin = mode_switch & input_switch;
  assign ref_to_comparator = mode_ref & refgen_enable;
  // Sleep does not gate power: an enabled comparator keeps running.
  assign comparator_power = mode_on;

  // Raw decision straight to the pin, bypassing the clock.
  assign comparator_output_pin_o = mode_output & raw_polar;
  assign comparator_output_pin_oe = mode_output & ~pin_direction_out_n;

  // ===================================================================
  // Reference ladder
  assign refgen_enable = refgen_ctrl[`CRG_REF_ENABLE_BIT];
  assign ref_range_sel = refgen_ctrl[`CRG_REF_RANGE_BIT];
  assign ref_tap_sel = refgen_ctrl[`CRG_REF_TAP_MSB:0];
  // Level code: msb 1 = low range (tap/24), 0 = high (1/4 + tap/32);
  // zero while powered down so the ladder draws nothing.
  assign ref_level_code = refgen_enable ? {ref_range_sel, ref_tap_sel} :
                          {(TAP_W+1){1'b0}};

  // ===================================================================
  // Shared port read
  // Pins 0 and 1 are analog while the comparator uses them; pin 2 is
  // analog only in reset mode. Off mode frees all pins as digital.
  wire pins01_analog = (mode != `CRG_MODE_OFF);
  wire pin2_analog = (mode == `CRG_MODE_RESET);
  wire [2:0] pin_analog = {pin2_analog, pins01_analog, pins01_analog};
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp = gp + 1) begin : g_pin
      // Pins are asynchronous: two flops before anything reads them
      reg sync_a_bit;
      reg sync_b_bit;
      always @(posedge clk) begin
        if (reset) begin
          sync_a_bit <= 1'b0;
          sync_b_bit <= 1'b0;
        end else begin
          sync_a_bit <= port_pins_in[gp];
          sync_b_bit <= sync_a_bit;
        end
      end
      // Analog pins read zero; digital pins read their synced level
      assign port_read[gp] = sync_b_bit & ~pin_analog[gp];
    end
  endgenerate

  // ===================================================================
  // AXI4-Lite slave
  // Address and data may arrive in either order; the early half is
  // parked until its partner comes. No new write while bvalid stands.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire aw_now = aw_held | s_axi_awvalid;
  wire w_now = w_held | s_axi_wvalid;
  wire wr_fire = aw_now & w_now & ~s_axi_bvalid;
  wire [`CRG_ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire [7:0] wr_idx = wr_addr[`CRG_ADDR_W-1:2];
  wire wr_lane0 = wr_strb[0];
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_idx = s_axi_araddr[`CRG_ADDR_W-1:2];

  wire wr_cmp = wr_fire && (wr_idx == `CRG_IDX_CMP_CTRL);
  wire wr_ref = wr_fire && (wr_idx == `CRG_IDX_REF_CTRL);
  wire wr_stat = wr_fire && (wr_idx == `CRG_IDX_STATUS);
  wire rd_cmp = rd_fire && (rd_idx == `CRG_IDX_CMP_CTRL);
  wire wr_known = wr_cmp | wr_ref | wr_stat;

  always @(posedge clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`CRG_ADDR_W{1'b0}};
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~wr_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `CRG_RESP_OKAY : `CRG_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data; unmapped indexes read zero and answer with an error
  reg [31:0] rd_word;
  reg rd_known;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_known = 1'b0;
    case (rd_idx)
      `CRG_IDX_CMP_CTRL: begin
        rd_known = 1'b1;
        rd_word[4:0] = comparator_ctrl;
        rd_word[`CRG_CMP_RESULT_BIT] = comparator_result;
      end
      `CRG_IDX_REF_CTRL: begin
        rd_known = 1'b1;
        rd_word[7:0] = refgen_ctrl & `CRG_REF_WR_MASK;
      end
      `CRG_IDX_STATUS: begin
        rd_known = 1'b1;
        rd_word[`CRG_STAT_FLAG_BIT] = flag;
        rd_word[`CRG_STAT_MISMATCH_BIT] = mismatch;
        rd_word[`CRG_STAT_SLEEP_BIT] = sleep_active;
      end
      `CRG_IDX_PINS: begin
        rd_known = 1'b1;
        rd_word[2:0] = port_read;
      end
      default: begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CRG_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? `CRG_RESP_OKAY : `CRG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ===================================================================
  // Control registers
  // Only reset and bus writes touch these; sleep and wake leave them as they are.
  always @(posedge clk) begin
    if (reset) begin
      comparator_ctrl <= `CRG_CMP_RESET;
      refgen_ctrl <= `CRG_REF_RESET;
    end else begin
      if (wr_cmp && wr_lane0) begin
        comparator_ctrl <= wr_data[4:0] & `CRG_CMP_WR_MASK;
      end
      if (wr_ref && wr_lane0) begin
        refgen_ctrl <= wr_data[7:0] & `CRG_REF_WR_MASK;
      end
    end
  end

  // ===================================================================
  // Change event
  // Mismatch: synced result differs from the value last latched by an
  // access to comparator_ctrl. It keeps re-setting the flag, so a mode
  // change without masking can fake an event.
  reg latched;
  always @(posedge clk) begin
    if (reset) begin
      latched <= 1'b0;
    end else if (rd_cmp | wr_cmp) begin
      latched <= comparator_result;
    end
  end
  // An access in this cycle ends the mismatch at once
  always @(posedge clk) begin
    if (reset) begin
      mismatch <= 1'b0;
    end else begin
      mismatch <= ~(rd_cmp | wr_cmp) & (comparator_result != latched);
    end
  end
  // A hardware set beats a software clear landing in the same cycle,
  // so no change can be lost to a racing clear.
  always @(posedge clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (result_changed | mismatch) begin
      flag <= 1'b1;
    end else if (wr_stat && wr_lane0) begin
      flag <= wr_data[`CRG_STAT_FLAG_BIT];
    end
  end

  assign cmp_event_flag = flag;
  assign wake_request = flag & sleep_active & mode_on;

endmodule // crg_top

`default_nettype wire

// [crg_top_props.sv]
// Checker for the comparator and reference control block.
// Assumes it is bound to crg_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module crg_top_props #(
  parameter TAP_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched signals
  input wire logic s_axi_bvalid,
  input wire logic comparator_raw,
  input wire logic [2:0] comparator_mode_sel,
  input wire logic input_switch,
  input wire logic neg_to_noninv_pin,
  input wire logic ref_to_comparator,
  input wire logic comparator_power,
  input wire logic refgen_enable,
  input wire logic ref_range_sel,
  input wire logic [TAP_W-1:0] ref_tap_sel,
  input wire logic [TAP_W:0] ref_level_code,
  input wire logic pin_direction_out_n,
  input wire logic comparator_output_pin_o,
  input wire logic comparator_output_pin_oe,
  input wire logic sleep_active,
  input wire logic wake_request,
  input wire logic cmp_event_flag
);
  // Mode masks: output modes 001/011/110, reference modes 010/100/101/110
  localparam logic [7:0] OUT_MODES = 8'h4A;
  localparam logic [7:0] REF_MODES = 8'h74;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==================================================================
  // Properties
  property p_oe;
    comparator_output_pin_oe == (OUT_MODES[comparator_mode_sel] && !pin_direction_out_n);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_pin_zero;
    !OUT_MODES[comparator_mode_sel] |-> !comparator_output_pin_o;
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("pin driven in plain mode");
  property p_power;
    comparator_power == (comparator_mode_sel != 3'h0 && comparator_mode_sel != 3'h7);
  endproperty
  a_power: assert property (p_power) else $error("power wrong");
  property p_ref_to;
    ref_to_comparator == (REF_MODES[comparator_mode_sel] && refgen_enable);
  endproperty
  a_ref_to: assert property (p_ref_to) else $error("reference routing wrong");
  property p_neg;
    neg_to_noninv_pin == (input_switch && (comparator_mode_sel inside {3'h5, 3'h6}));
  endproperty
  a_neg: assert property (p_neg) else $error("input switch wrong");
  property p_level;
    ref_level_code == (refgen_enable ? {ref_range_sel, ref_tap_sel} : '0);
  endproperty
  a_level: assert property (p_level) else $error("ladder code wrong");
  property p_wake;
    wake_request == (sleep_active && cmp_event_flag && comparator_power);
  endproperty
  a_wake: assert property (p_wake) else $error("wake wrong");
  // Raw change must reach the flag through the two-stage synchroniser
  property p_flag;
    $changed(comparator_output_pin_o) && $stable(comparator_mode_sel) &&
      OUT_MODES[comparator_mode_sel] |-> ##[2:4] cmp_event_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set on change");
  property p_flag_sticky;
    $fell(cmp_event_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
endmodule // crg_top_props
bind crg_top crg_top_props #(.TAP_W(TAP_W)) u_crg_top_props (
  .clk, .reset, .s_axi_bvalid, .comparator_raw, .comparator_mode_sel, .input_switch,
  .neg_to_noninv_pin, .ref_to_comparator, .comparator_power, .refgen_enable,
  .ref_range_sel, .ref_tap_sel, .ref_level_code, .pin_direction_out_n,
  .comparator_output_pin_o, .comparator_output_pin_oe, .sleep_active, .wake_request,
  .cmp_event_flag
);
`default_nettype wire

// [crg_top_bench.sv]
// Self-checking bench for the comparator and reference control block.
// Assumes crg_top and its header; drives every port itself.
`include "crg_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module crg_top_bench;
  localparam logic [9:0] A_CMP = {`CRG_IDX_CMP_CTRL, 2'h0};
  localparam logic [9:0] A_REF = {`CRG_IDX_REF_CTRL, 2'h0};
  localparam logic [9:0] A_STAT = {`CRG_IDX_STATUS, 2'h0};
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic comparator_raw = 1'h0, pin_direction_out_n = 1'h1, sleep_active = 1'h0;
  logic [2:0] port_pins_in = 3'h7;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] comparator_mode_sel, port_read;
  wire input_switch, neg_to_noninv_pin, ref_to_comparator, comparator_power, refgen_enable;
  wire ref_range_sel, comparator_output_pin_o, comparator_output_pin_oe;
  wire wake_request, cmp_event_flag;
  wire [3:0] ref_tap_sel;
  wire [4:0] ref_level_code;
  int n_mismatch = 0;
  int compares = 0;
  logic [31:0] rv;
  logic [1:0] resp;

  crg_top #(.TAP_W(4)) u_crg_top (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_raw, .comparator_mode_sel,
    .input_switch, .neg_to_noninv_pin, .ref_to_comparator, .comparator_power,
    .refgen_enable, .ref_range_sel, .ref_tap_sel, .ref_level_code,
    .pin_direction_out_n, .comparator_output_pin_o, .comparator_output_pin_oe,
    .port_pins_in, .port_read, .sleep_active, .wake_request, .cmp_event_flag
  );

  always #2 clk = ~clk;

  // ==================================================================
  // Bus and check tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bready stays up from the start; an extra edge keeps drivers single-assigned
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_reset();
    rd(A_CMP); chk("cmp reset", rv, 32'h0);
    rd(A_REF); chk("ref reset", rv, 32'h0);
    chk("analog pins", port_read, 3'h0);
  endtask
  task automatic t_bits();
    wr(A_CMP, 32'hFF);
    repeat (4) @(posedge clk);
    rd(A_CMP); chk("ro bits", rv, 32'h5F);
    chk("inverted", rv[6], 1'h1);
    chk("switch bit", input_switch, 1'h1);
    wr(A_CMP, 32'h0E);
    comparator_raw <= 1'h1;
    pin_direction_out_n <= 1'h0;
    repeat (4) @(posedge clk);
    rd(A_CMP); chk("result", rv, 32'h4E);
    chk("neg switch", neg_to_noninv_pin, 1'h1);
    chk("pin", comparator_output_pin_o, 1'h1);
    chk("pin oe", comparator_output_pin_oe, 1'h1);
    pin_direction_out_n <= 1'h1;
    wr(A_CMP, 32'h06); chk("switch off", neg_to_noninv_pin, 1'h0);
    chk("pin oe off", comparator_output_pin_oe, 1'h0);
  endtask
  task automatic t_modes();
    int nref;
    nref = 0;
    wr(A_REF, 32'h80);
    for (int m = 0; m < 8; m++) begin
      wr(A_CMP, m);
      chk("mode sel", comparator_mode_sel, m);
      chk("power", comparator_power, m != 0 && m != 7);
      nref += ref_to_comparator;
    end
    chk("ref modes", nref, 4);
    chk("digital pins", port_read, 3'h7);
  endtask
  task automatic t_ref();
    wr(A_REF, 32'hFF); rd(A_REF); chk("ref ro", rv, 32'hAF);
    wr(A_REF, 32'hA5); chk("low range", ref_level_code, 5'h15);
    chk("range bit", ref_range_sel, 1'h1);
    chk("ladder on", refgen_enable, 1'h1);
    wr(A_REF, 32'h8F); chk("high range", ref_level_code, 5'h0F);
    chk("tap", ref_tap_sel, 4'hF);
    wr(A_REF, 32'h2F); chk("ladder off", ref_level_code, 5'h0);
  endtask
  task automatic t_flag();
    wr(A_CMP, 32'h06);
    wr(A_STAT, 32'h0); chk("flag clear", cmp_event_flag, 1'h0);
    comparator_raw <= 1'h0;
    repeat (4) @(posedge clk);
    chk("flag set", cmp_event_flag, 1'h1);
    wr(A_STAT, 32'h0); rd(A_STAT); chk("mismatch", rv[0], 1'h1);
    chk("mismatch bit", rv[1], 1'h1);
    rd(A_CMP); wr(A_STAT, 32'h0); chk("cleared", cmp_event_flag, 1'h0);
    wr(A_STAT, 32'h1); chk("soft set", cmp_event_flag, 1'h1);
    sleep_active <= 1'h1;
    @(posedge clk);
    chk("wake", wake_request, 1'h1);
    rd(A_CMP); chk("kept", rv, 32'h06);
    sleep_active <= 1'h0;
  endtask
  task automatic t_bad();
    wr(10'h3FC, 32'hFF); chk("bad write", resp, `CRG_RESP_SLVERR);
    rd(10'h3FC); chk("bad read", resp, `CRG_RESP_SLVERR);
    rd(A_CMP); chk("no effect", rv, 32'h06);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    t_reset();
    t_bits();
    t_modes();
    t_ref();
    t_flag();
    t_bad();
    final_report();
  end
endmodule // crg_top_bench
`default_nettype wire
